// ### logic/mailbox_consts.svh
`ifndef MAILBOX_CONSTS_SVH
`define MAILBOX_CONSTS_SVH
`define FC_RD_HOLD 8'h03
`define FC_RD_INPUT 8'h04
`define FC_WR_SINGLE 8'h06
`define FC_WR_MULTI 8'h10
`define START_ADDR 16'h0000
`define MSG_WORDS 16'h0009
`define MSG_LAST_WORD 4'h8
`define MAX_READ_WORDS 16'h0075
`define TX_WORDS 16'h0007
`define TX_LAST_REG 16'h0006
`define TX_BYTE_CNT 8'h0d
`define TX_HOLD_BYTES 8'h0e
`define REQ_SHORT_LEN 5'h08
`define REQ_MULTI_LEN 5'h17
`define REQ_MIN_LEN 5'h04
`define HDR_LEN 8'h03
`define ECHO_LEN 8'h06
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define FIFO_DEPTH 16
`define MSG_WIDTH 144
`define RX_BUF_LEN 24
`define SPEC_IDS 4
`endif

// ### logic/mailbox_pkg.sv
package mailbox_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_EXEC, ST_LOAD, ST_SEND} link_state_t;
   typedef enum logic [1:0] {RSP_READ_IN, RSP_READ_HOLD, RSP_ECHO, RSP_EXCEPT} resp_kind_t;
   typedef logic [15:0] word_t;
endpackage : mailbox_pkg

// ### logic/msg_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module msg_fifo #(
   parameter int WIDTH = 144,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic inValid, // Write side offers a word
   input wire logic [WIDTH-1:0] inData, // Word to store
   output logic inReady, // Room for one more word
   output logic outValid, // Head word present
   output logic [WIDTH-1:0] outData, // Head word
   input wire logic outReady // Drain side takes the head
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [WIDTH-1:0] next_mem [0:DEPTH-1];
   logic [AW:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
   logic doPush, doPop;

   // Extra pointer bit tells full from empty without a separate counter
   assign inReady = (wrPtr[AW-1:0] != rdPtr[AW-1:0]) || (wrPtr[AW] == rdPtr[AW]);
   assign outValid = wrPtr != rdPtr;
   assign outData = mem[rdPtr[AW-1:0]];
   assign doPush = inValid && inReady;
   assign doPop = outReady && outValid;

   // Next pointers and storage
   always_comb
   begin
      next_mem = mem;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      if (doPush)
      begin
         next_mem[wrPtr[AW-1:0]] = inData;
         next_wrPtr = wrPtr + 1'b1;
      end
      if (doPop)
         next_rdPtr = rdPtr + 1'b1;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= '0;
      end
      else
      begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         mem <= next_mem;
      end
   end
endmodule : msg_fifo
`default_nettype wire

// ### logic/can_mailbox.sv
`timescale 1ns/100ps
`default_nettype none
`include "mailbox_consts.svh"
module can_mailbox (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic [7:0] nodeAddr, // Own Modbus node address
   input wire logic [7:0] rxByte, // Received serial byte
   input wire logic rxValid, // One-cycle strobe with rxByte
   input wire logic rxFrameEnd, // One-cycle strobe: line silent, frame over
   output logic [7:0] txByte, // Answer byte to the serial sender
   output logic txValid, // txByte is offered
   input wire logic txReady, // Serial sender takes txByte
   input wire logic canRxValid, // Received CAN frame offered
   input wire logic [28:0] canRxId, // Its identifier
   input wire logic canRxExt, // Extended identifier
   input wire logic canRxRtr, // Remote frame
   input wire logic [3:0] canRxDlc, // Data length code
   input wire logic [63:0] canRxData, // Data, first byte in the top bits
   output logic canRxReady, // Frame taken
   input wire logic [`SPEC_IDS-1:0] specIdValid, // Special list entries in use
   input wire logic [28:0] specIdTable [0:`SPEC_IDS-1], // Specially handled identifiers
   output logic canTxValid, // Frame waiting for the transmit buffer
   input wire logic canTxReady, // Controller buffer takes the frame
   output logic [28:0] canTxId, // Outbound identifier
   output logic canTxExt, // Outbound extended flag
   output logic canTxRtr, // Outbound remote flag
   output logic [3:0] canTxDlc, // Outbound length code
   output logic [63:0] canTxData // Outbound data
);
   import mailbox_pkg::*;

   link_state_t state, next_state;
   resp_kind_t kind, next_kind;
   logic [7:0] rxBuf [0:`RX_BUF_LEN-1];
   logic [7:0] next_rxBuf [0:`RX_BUF_LEN-1];
   logic [4:0] rxCnt, next_rxCnt;
   logic rxOver, next_rxOver;
   word_t rxCrc, next_rxCrc, txCrc, next_txCrc;
   logic [7:0] respIdx, next_respIdx, respLen, next_respLen;
   logic [7:0] respFc, next_respFc, excCode, next_excCode;
   logic [7:0] next_txByte;
   logic [3:0] wordSel, next_wordSel;
   word_t txRec [0:6];
   word_t next_txRec [0:6];
   logic launch;
   logic [31:0] stamp, next_stamp;
   logic next_canTxValid;
   logic [28:0] next_canTxId;
   logic next_canTxExt, next_canTxRtr;
   logic [3:0] next_canTxDlc;
   logic [63:0] next_canTxData;
   logic [`SPEC_IDS-1:0] idHit;
   logic specHit, pushValid, fifoInReady, headValid, popReq;
   logic [`MSG_WIDTH-1:0] pushData, headData;
   word_t headWord, reqStart, reqCount;
   logic reqOk;

   // Modbus RTU CRC-16, reflected, one byte at a time
   function automatic word_t crcByte(input word_t c, input logic [7:0] b);
      word_t r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      return r;
   endfunction : crcByte

   // Identifier compare against every special list entry
   generate
      for (genvar g = 0; g < `SPEC_IDS; g++)
      begin : g_spec
         assign idHit[g] = specIdValid[g] && (specIdTable[g] == canRxId);
      end
   endgenerate

   // Special frames are taken and dropped here; the rest queue up
   assign specHit = |idHit;
   assign pushValid = canRxValid && !specHit;
   assign canRxReady = specHit || fifoInReady;
   assign pushData = {8'h00, 2'b00, canRxExt, canRxRtr, canRxDlc, 3'b000, canRxId,
                      canRxData, stamp};

   msg_fifo #(.WIDTH(`MSG_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .inValid(pushValid),
      .inData(pushData),
      .inReady(fifoInReady),
      .outValid(headValid),
      .outData(headData),
      .outReady(popReq)
   );

   // Head record word; an empty queue reads as zeros
   assign headWord = headValid ? headData[(`MSG_WIDTH-1) - 16*wordSel -: 16] : 16'h0000;
   assign reqStart = {rxBuf[2], rxBuf[3]};
   assign reqCount = {rxBuf[4], rxBuf[5]};
   // Frames for other nodes or with a bad checksum end here without an answer
   assign reqOk = (rxCnt >= `REQ_MIN_LEN) && !rxOver && (rxCrc == 16'h0000)
                  && (rxBuf[0] == nodeAddr);
   assign txValid = (state == ST_SEND);
   // Pop once the last word of a record has left the line
   assign popReq = (state == ST_SEND) && txReady && (kind == RSP_READ_IN)
                   && (respIdx >= `HDR_LEN) && (respIdx < respLen) && !respIdx[0]
                   && (wordSel == `MSG_LAST_WORD) && headValid;

   // Receive, decode and answer
   always_comb
   begin
      next_state = state;
      next_kind = kind;
      next_rxBuf = rxBuf;
      next_rxCnt = rxCnt;
      next_rxOver = rxOver;
      next_rxCrc = rxCrc;
      next_txCrc = txCrc;
      next_respIdx = respIdx;
      next_respLen = respLen;
      next_respFc = respFc;
      next_excCode = excCode;
      next_txByte = txByte;
      next_wordSel = wordSel;
      next_txRec = txRec;
      launch = 1'b0;
      case (state)
         ST_IDLE, ST_RECV:
         begin
            if (rxValid)
            begin
               if (rxCnt < 5'(`RX_BUF_LEN))
                  next_rxBuf[rxCnt] = rxByte;
               else
                  next_rxOver = 1'b1;
               next_rxCnt = (rxCnt == 5'h1f) ? rxCnt : rxCnt + 5'h01;
               next_rxCrc = crcByte(rxCrc, rxByte);
               next_state = ST_RECV;
            end
            if (rxFrameEnd && state == ST_RECV)
               next_state = ST_EXEC;
         end
         ST_EXEC:
         begin
            next_state = ST_LOAD;
            next_respIdx = 8'h00;
            next_wordSel = 4'h0;
            next_txCrc = `CRC_INIT;
            next_respFc = rxBuf[1];
            next_kind = RSP_EXCEPT;
            next_respLen = `HDR_LEN;
            next_excCode = `EXC_FUNC;
            if (!reqOk)
               next_state = ST_IDLE;
            else if (rxCnt != `REQ_SHORT_LEN && rxBuf[1] != `FC_WR_MULTI)
               next_state = ST_IDLE;
            else
               case (rxBuf[1])
                  `FC_RD_INPUT:
                  begin
                     // Whole nine-word records only, read from register 0
                     if (reqStart != `START_ADDR)
                        next_excCode = `EXC_ADDR;
                     else if (reqCount == 16'h0000 || reqCount > `MAX_READ_WORDS
                              || (reqCount % `MSG_WORDS) != 16'h0000)
                        next_excCode = `EXC_VALUE;
                     else
                     begin
                        next_kind = RSP_READ_IN;
                        next_respLen = `HDR_LEN + 8'(reqCount << 1);
                     end
                  end
                  `FC_RD_HOLD:
                  begin
                     if (reqStart != `START_ADDR)
                        next_excCode = `EXC_ADDR;
                     else if (reqCount != `TX_WORDS)
                        next_excCode = `EXC_VALUE;
                     else
                     begin
                        next_kind = RSP_READ_HOLD;
                        next_respLen = `HDR_LEN + `TX_HOLD_BYTES;
                     end
                  end
                  `FC_WR_MULTI:
                  begin
                     if (rxCnt != `REQ_MULTI_LEN)
                        next_state = ST_IDLE;
                     else if (reqStart != `START_ADDR)
                        next_excCode = `EXC_ADDR;
                     else if (reqCount != `TX_WORDS || rxBuf[6] != `TX_BYTE_CNT)
                        next_excCode = `EXC_VALUE;
                     else
                     begin
                        for (int i = 0; i < 7; i++)
                           next_txRec[i] = {rxBuf[7 + 2*i], rxBuf[8 + 2*i]};
                        launch = 1'b1;
                        next_kind = RSP_ECHO;
                        next_respLen = `ECHO_LEN;
                     end
                  end
                  `FC_WR_SINGLE:
                  begin
                     if (reqStart > `TX_LAST_REG)
                        next_excCode = `EXC_ADDR;
                     else
                     begin
                        // Register by register; the last one releases the frame
                        next_txRec[reqStart[2:0]] = reqCount;
                        launch = (reqStart == `TX_LAST_REG);
                        next_kind = RSP_ECHO;
                        next_respLen = `ECHO_LEN;
                     end
                  end
                  default: ;
               endcase
         end
         ST_LOAD:
         begin
            // Byte for the current index, crc bytes after the body
            next_state = ST_SEND;
            if (respIdx == respLen)
               next_txByte = txCrc[7:0];
            else if (respIdx == respLen + 8'h01)
               next_txByte = txCrc[15:8];
            else if (respIdx == 8'h00)
               next_txByte = nodeAddr;
            else if (respIdx == 8'h01)
               next_txByte = (kind == RSP_EXCEPT) ? (respFc | `EXC_FLAG) : respFc;
            else
               case (kind)
                  RSP_READ_IN:
                     next_txByte = (respIdx == 8'h02) ? (respLen - `HDR_LEN) :
                                   (respIdx[0] ? headWord[15:8] : headWord[7:0]);
                  RSP_READ_HOLD:
                     next_txByte = (respIdx == 8'h02) ? `TX_HOLD_BYTES :
                                   (respIdx[0] ? txRec[3'((respIdx - 8'h03) >> 1)][15:8]
                                               : txRec[3'((respIdx - 8'h03) >> 1)][7:0]);
                  RSP_ECHO:
                     next_txByte = rxBuf[respIdx[2:0]];
                  default:
                     next_txByte = excCode;
               endcase
         end
         ST_SEND:
         begin
            if (txReady)
            begin
               if (respIdx < respLen)
                  next_txCrc = crcByte(txCrc, txByte);
               if (kind == RSP_READ_IN && respIdx >= `HDR_LEN && !respIdx[0]
                   && respIdx < respLen)
                  next_wordSel = (wordSel == `MSG_LAST_WORD) ? 4'h0 : wordSel + 4'h1;
               next_respIdx = respIdx + 8'h01;
               next_state = (respIdx == respLen + 8'h01) ? ST_IDLE : ST_LOAD;
               if (respIdx == respLen + 8'h01)
               begin
                  next_rxCnt = 5'h00;
                  next_rxOver = 1'b0;
                  next_rxCrc = `CRC_INIT;
               end
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
      // A frame dropped without an answer also frees the receive buffer
      if (state == ST_EXEC && next_state == ST_IDLE)
      begin
         next_rxCnt = 5'h00;
         next_rxOver = 1'b0;
         next_rxCrc = `CRC_INIT;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         kind <= RSP_EXCEPT;
         rxCnt <= 5'h00;
         rxOver <= 1'b0;
         rxCrc <= `CRC_INIT;
         txCrc <= `CRC_INIT;
         respIdx <= 8'h00;
         respLen <= 8'h00;
         respFc <= 8'h00;
         excCode <= 8'h00;
         txByte <= 8'h00;
         wordSel <= 4'h0;
         for (int i = 0; i < `RX_BUF_LEN; i++)
            rxBuf[i] <= 8'h00;
         for (int i = 0; i < 7; i++)
            txRec[i] <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         kind <= next_kind;
         rxCnt <= next_rxCnt;
         rxOver <= next_rxOver;
         rxCrc <= next_rxCrc;
         txCrc <= next_txCrc;
         respIdx <= next_respIdx;
         respLen <= next_respLen;
         respFc <= next_respFc;
         excCode <= next_excCode;
         txByte <= next_txByte;
         wordSel <= next_wordSel;
         rxBuf <= next_rxBuf;
         txRec <= next_txRec;
      end
   end

   // Transmit hand-off; the controller sends when the bus goes idle
   always_comb
   begin
      next_stamp = stamp + 32'h0000_0001;
      next_canTxValid = canTxValid;
      next_canTxId = canTxId;
      next_canTxExt = canTxExt;
      next_canTxRtr = canTxRtr;
      next_canTxDlc = canTxDlc;
      next_canTxData = canTxData;
      if (canTxValid && canTxReady)
         next_canTxValid = 1'b0;
      // New record wins over a same-cycle take; it also overwrites a frame still waiting
      if (launch)
      begin
         next_canTxValid = 1'b1;
         next_canTxExt = next_txRec[0][5];
         next_canTxRtr = next_txRec[0][4];
         next_canTxDlc = next_txRec[0][3:0];
         next_canTxId = {next_txRec[1][12:0], next_txRec[2]};
         next_canTxData = {next_txRec[3], next_txRec[4], next_txRec[5], next_txRec[6]};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         stamp <= 32'h0000_0000;
         canTxValid <= 1'b0;
         canTxId <= 29'h0000_0000;
         canTxExt <= 1'b0;
         canTxRtr <= 1'b0;
         canTxDlc <= 4'h0;
         canTxData <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         stamp <= next_stamp;
         canTxValid <= next_canTxValid;
         canTxId <= next_canTxId;
         canTxExt <= next_canTxExt;
         canTxRtr <= next_canTxRtr;
         canTxDlc <= next_canTxDlc;
         canTxData <= next_canTxData;
      end
   end

   // Checks
   sequence byteTaken;
      state == ST_SEND && txReady;
   endsequence
   sequence execBad;
      state == ST_EXEC && !reqOk;
   endsequence

   AST_DROP_SPECIAL: assert property (@(posedge clk_sys) disable iff (!nrst)
      canRxValid && specHit |-> !pushValid && canRxReady)
      else $error("special frame entered the queue");
   AST_QUEUE_NORMAL: assert property (@(posedge clk_sys) disable iff (!nrst)
      canRxValid && !specHit && fifoInReady |=> headValid)
      else $error("normal frame not queued");
   AST_IGNORE_BAD: assert property (@(posedge clk_sys) disable iff (!nrst)
      execBad |=> state == ST_IDLE && !txValid [*2])
      else $error("bad request answered");
   AST_READ_START: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_LOAD && kind == RSP_READ_IN |-> reqStart == 16'h0000)
      else $error("queue read with nonzero start");
   AST_READ_MULT9: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_LOAD && kind == RSP_READ_IN |-> ((respLen - 8'h03) % 8'd18) == 8'h00)
      else $error("queue read length not whole records");
   AST_POP_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
      popReq |-> kind == RSP_READ_IN && wordSel == 4'h8 && !respIdx[0])
      else $error("record popped mid-way");
   AST_LAUNCH_TX: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch |=> canTxValid && canTxDlc == txRec[0][3:0])
      else $error("written record not handed to controller");
   AST_TX_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
      canTxValid && !canTxReady && !launch |=> canTxValid && $stable(canTxId))
      else $error("pending frame withdrawn");
   AST_FC_ECHO: assert property (@(posedge clk_sys) disable iff (!nrst)
      byteTaken ##0 (respIdx == 8'h00) |-> ##2 (txByte[6:0] == respFc[6:0]))
      else $error("function code not returned second");
   AST_HOLD_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_LOAD && kind == RSP_READ_HOLD |-> respLen == 8'h11)
      else $error("read-back length wrong");
endmodule : can_mailbox
`default_nettype wire

// ### sim/modbus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// Serial master stand-in: framed requests in, answers taken with random stalls
module modbus_master_model (
   input wire logic clk_sys, // System clock
   output logic [7:0] rxByte, // Request byte
   output logic rxValid, // Byte strobe
   output logic rxFrameEnd, // End-of-frame strobe
   output logic txReady // Answer byte taken
);
   int seed = 7;
   initial {rxByte, rxValid, rxFrameEnd} = '0; // txReady has a process of its own
   // Stalls make the slave hold each answer byte
   always @(posedge clk_sys) txReady <= #1 1'($random(seed));
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i])
      begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction : crc16
   // CRC goes low byte first; a corrupt one only when asked
   task automatic send_req(input logic [7:0] q[$], input bit bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i])
      begin
         @(posedge clk_sys);
         #1 rxByte = q[i];
         rxValid = 1'b1;
      end
      @(posedge clk_sys);
      #1 rxValid = 1'b0;
      rxByte = ~rxByte; // Idle line never repeats the last byte
      repeat (3) @(posedge clk_sys);
      #1 rxFrameEnd = 1'b1;
      @(posedge clk_sys);
      #1 rxFrameEnd = 1'b0;
   endtask : send_req
endmodule : modbus_master_model
`default_nettype wire

// ### sim/can_mailbox_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %0t %s", $time, m); end end
module can_mailbox_bench;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] rxByte, txByte;
   logic rxValid, rxFrameEnd, txValid, txReady, canRxReady, canTxValid, canTxExt, canTxRtr;
   logic canRxValid = 1'b0;
   logic canTxReady = 1'b0;
   logic [98:0] rxF = '0; // Frame: ext, rtr, dlc, id, data
   logic [28:0] canTxId;
   logic [3:0] canTxDlc;
   logic [63:0] canTxData;
   logic [28:0] spec [0:3] = '{29'h0abcdef, 29'h0, 29'h0, 29'h0};
   logic [8:0] expQ[$], e; // Bit 8 marks a byte left uncompared: a stamp byte, or a crc byte of an answer with stamps
   logic [98:0] canQ[$], txQ[$], f;
   logic [15:0] tw [0:6];
   int seed = 7;
   int mismatches = 0;
   int total_checks = 0;
   initial forever #5 clk_sys = ~clk_sys;
   can_mailbox dut (.clk_sys(clk_sys), .nrst(nrst), .nodeAddr(8'h01), .rxByte(rxByte),
      .rxValid(rxValid), .rxFrameEnd(rxFrameEnd), .txByte(txByte), .txValid(txValid),
      .txReady(txReady), .canRxValid(canRxValid), .canRxId(rxF[92:64]), .canRxExt(rxF[98]),
      .canRxRtr(rxF[97]), .canRxDlc(rxF[96:93]), .canRxData(rxF[63:0]),
      .canRxReady(canRxReady), .specIdValid(4'h1), .specIdTable(spec),
      .canTxValid(canTxValid), .canTxReady(canTxReady), .canTxId(canTxId),
      .canTxExt(canTxExt), .canTxRtr(canTxRtr), .canTxDlc(canTxDlc), .canTxData(canTxData));
   modbus_master_model mm (.clk_sys(clk_sys), .rxByte(rxByte), .rxValid(rxValid),
      .rxFrameEnd(rxFrameEnd), .txReady(txReady));
   // Outputs are matched in order against the notes left by the drivers
   always @(posedge clk_sys)
   begin
      canTxReady <= #1 1'($random(seed));
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
         if (expQ.size() == 0) `CHK(1'b1, 1'b0, "stray answer byte")
         else
         begin
            e = expQ.pop_front();
            if (!e[8]) `CHK(txByte, e[7:0], "answer byte")
         end
      end
      if (canTxValid === 1'b1 && canTxReady === 1'b1)
      begin
         f = txQ.size() > 0 ? txQ.pop_front() : 'x;
         `CHK({canTxExt, canTxRtr, canTxDlc, canTxId, canTxData}, f, "CAN tx")
      end
   end
   task automatic wd(ref logic [8:0] a[$], input logic [15:0] v, input bit m);
      a.push_back({m, v[15:8]});
      a.push_back({m, v[7:0]});
   endtask : wd
   // Notes the answer, sends the request, waits a bounded time for the answer
   task automatic req(input logic [7:0] q[$], input logic [8:0] a[$], input bit bad);
      logic [7:0] b[$];
      logic [15:0] c;
      bit m = 0;
      int n = 0;
      foreach (a[i])
      begin
         b.push_back(a[i][7:0]);
         m |= a[i][8];
         expQ.push_back(a[i]);
      end
      c = mm.crc16(b);
      if (a.size() > 0) wd(expQ, {c[7:0], c[15:8]}, m);
      mm.send_req(q, bad);
      while (expQ.size() > 0 && n++ < 4000) @(posedge clk_sys);
      `CHK(expQ.size(), 0, "answer missing")
      repeat (20) @(posedge clk_sys);
   endtask : req
   // Records leave the queue oldest first; an empty queue reads as zeros
   task automatic rd(input logic [15:0] cnt);
      logic [8:0] a[$];
      logic [98:0] g;
      a = '{9'h001, 9'h004, {1'b0, cnt[6:0], 1'b0}};
      repeat (cnt / 9)
      begin
         g = canQ.size() > 0 ? canQ.pop_front() : '0;
         wd(a, {10'h0, g[98:93]}, 0);
         wd(a, {3'h0, g[92:80]}, 0);
         wd(a, g[79:64], 0);
         for (int i = 3; i >= 0; i--) wd(a, g[i*16 +: 16], 0);
         wd(a, 16'h0, g != '0);
         wd(a, 16'h0, g != '0);
      end
      req('{8'h01, 8'h04, 8'h00, 8'h00, cnt[15:8], cnt[7:0]}, a, 0);
   endtask : rd
   task automatic mkrec();
      for (int i = 0; i < 7; i++) tw[i] = 16'($random(seed));
      tw[0] = {10'h0, tw[0][5:4], 4'(tw[0][3:0] % 9)};
      tw[1][15:13] = 3'h0;
      txQ.push_back({tw[0][5:0], tw[1][12:0], tw[2], tw[3], tw[4], tw[5], tw[6]});
   endtask : mkrec
   task automatic rb();
      logic [8:0] a[$];
      a = '{9'h001, 9'h003, 9'h00e};
      foreach (tw[i]) wd(a, tw[i], 0);
      req('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07}, a, 0);
      `CHK(txQ.size(), 0, "written frame never handed over")
   endtask : rb
   // Offers one CAN frame and holds it until the edge that takes it
   task automatic cin(input logic [28:0] id);
      @(posedge clk_sys);
      #1 canRxValid = 1'b1;
      rxF = {id[1:0], 4'(id % 9), id, 32'($random(seed)), 32'($random(seed))};
      if (id != spec[0]) canQ.push_back(rxF);
      @(posedge clk_sys);
      while (canRxReady !== 1'b1) @(posedge clk_sys);
      #1 canRxValid = 1'b0;
      rxF = ~rxF;
   endtask : cin
   task automatic finish_test();
      $display("CHECKS %0d MISMATCHES %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // Whole run needs far less than this span
   initial
   begin
      #500us;
      mismatches++;
      finish_test();
   end
   initial
   begin
      logic [7:0] q[$];
      logic [47:0] ex [8] = '{48'h04_0001_0009_02, 48'h04_0000_000a_03, 48'h04_0000_0000_03,
         48'h04_0000_0076_03, 48'h03_0000_0008_03, 48'h03_0001_0007_02,
         48'h06_0007_0000_02, 48'h05_0000_0001_01};
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      mkrec();
      q = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h07, 8'h0d};
      foreach (tw[i]) q = {q, tw[i][15:8], tw[i][7:0]};
      req(q, '{9'h001, 9'h010, 9'h000, 9'h000, 9'h000, 9'h007}, 0);
      rb();
      $display("TEST block write done");
      mkrec();
      foreach (tw[i]) req('{8'h01, 8'h06, 8'h00, 8'(i), tw[i][15:8], tw[i][7:0]},
         '{9'h001, 9'h006, 9'h000, 9'(i), {1'b0, tw[i][15:8]}, {1'b0, tw[i][7:0]}}, 0);
      rb();
      $display("TEST single writes done");
      foreach (ex[i]) req('{8'h01, ex[i][47:40], ex[i][39:32], ex[i][31:24], ex[i][23:16],
         ex[i][15:8]}, '{9'h001, {1'b0, ex[i][47:40] | 8'h80}, {1'b0, ex[i][7:0]}}, 0);
      req('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07}, '{}, 0);
      req('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h07}, '{}, 1);
      // Block write with a wrong byte count is refused and sends no frame
      q[6] = 8'h0e;
      req(q, '{9'h001, 9'h090, 9'h003}, 0);
      // Over-long frame overflows the receive buffer and gets no answer
      req({q, 8'h00, 8'h00, 8'h00}, '{}, 0);
      $display("TEST refusals done");
      cin(29'h1a2b3c4);
      cin(spec[0]);
      cin(29'h0000123);
      rd(16'h0012);
      rd(16'h0009);
      $display("TEST receive queue done");
      for (int i = 0; i < 16; i++) cin(29'h100 + i);
      @(posedge clk_sys);
      #1 canRxValid = 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK(canRxReady, 1'b0, "full queue took a frame")
      #1 canRxValid = 1'b0;
      rd(16'h0075);
      rd(16'h001b);
      rd(16'h0009);
      $display("TEST queue fill and drain done");
      finish_test();
   end
endmodule : can_mailbox_bench
`default_nettype wire
